// ---- logic/apt_defs.svh ----
`ifndef APT_DEFS_SVH
`define APT_DEFS_SVH
// ==========================================================
// Register map (byte addresses)
`define APT_REG_CTRL 12'h000
`define APT_REG_COUNT 12'h004
`define APT_REG_STATUS 12'h008
`define APT_REG_DATA 12'h00c
`define APT_REG_SWCONV 12'h010
// ==========================================================
// Control fields
`define APT_CTRL_SRC_LSB 0
`define APT_CTRL_TRIG_BIT 2
`define APT_CTRL_GATE_BIT 3
`define APT_CTRL_CASC_BIT 4
`define APT_CTRL_EOCIE_BIT 5
`define APT_CTRL_START_BIT 6
`define APT_CTRL_RESET 7'h00
// ==========================================================
// Status fields
`define APT_ST_EMPTY_BIT 0
`define APT_ST_FULL_BIT 1
`define APT_ST_OVR_BIT 2
`define APT_ST_BUSY_BIT 3
`define APT_ST_ARMED_BIT 4
// ==========================================================
// Timing
`define APT_CLK_MHZ 125
`define APT_TB_MHZ 1
`define APT_TB_DIV (`APT_CLK_MHZ / `APT_TB_MHZ)
`define APT_FAST_RESET 16'h0019
`define APT_SLOW_RESET 16'h0001
`endif

// ---- logic/apt_pkg.sv ----
package apt_pkg;
    typedef enum logic [1:0] {APT_SRC_SW, APT_SRC_INT, APT_SRC_EXT}
        apt_src_t;
    typedef enum logic [1:0] {APT_IDLE, APT_WAIT, APT_RUN} apt_state_t;
endpackage

// ---- logic/apt_top.sv ----
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "apt_defs.svh"
// Overview of operation
// (R1) Internal start converts at once, loads counter, converts and reloads at zero.
// (R2) Pacing counters decrement from a 1 MHz time base.
// (R3) Normal mode: fast counter alone paces each conversion.
// (R4) Cascaded: fast zero reloads and decrements slow; both zero converts.
// (R5) Base model starts fast counter on bus clock over two until internal.
// (R6) External source arms; every later external falling edge converts.
// (R7) External clock selected blocks that pin as interrupt source.
// (R8) External clock stays at or below 40 kHz.
// (R9) At gain 500 keep rate at or below 25 kHz.
// (R10) Software trigger starts conversions on start with no wait.
// (R11) Hardware trigger is a rising edge on trigger/gate input.
// (R12) Trigger with internal clock: counters idle, first conversion at trigger.
// (R13) Trigger with external clock: trigger arms, next falling edge converts.
// (R14) Gate is active high; conversions only while gate is high.
// (R15) Gate and trigger not together; gate low at start holds off.
// (R16) Gate with external clock stays aligned to external edges.
// (R17) Gate with internal clock stops counting, reloads on each rise.
// (R18) Four-entry FIFO stores each hardware-paced result.
// (R19) Software source disables FIFO logic and clears it.
// (R20) Overwrite of unread entries raises an overrun error.
// (R21) End-of-conversion interrupt, when enabled, flags a non-empty FIFO, or with software source any time sw_busy is low.
// (R22) Host reads every result from the data port; no DMA.
// (R23) Software conversion: host polls busy then reads result.
// (R24) Reset selects software-initiated conversions.
// (R25) Cascaded counters reload and keep pacing after each conversion.
module apt_top import apt_pkg::*; #(
    parameter int DATA_W = 12,
    parameter int DEPTH = 4,
    parameter bit BASE_MODEL = 1'b1
) (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic TRIGGER_GATE_INPUT,
    input wire logic EXT_CLOCK_IRQ_INPUT,
    output logic CONV_START,
    input wire logic CONV_DONE,
    input wire logic [DATA_W-1:0] CONV_DATA,
    output logic EXT_IRQ_REQ,
    output logic EOC_IRQ,
    output logic MASTER_PACE_OUTPUT
);
    initial begin
        if (DEPTH != 4 || DATA_W < 1 || DATA_W > 16)
            $error("apt_top: unsupported DEPTH or DATA_W");
    end
    // ==========================================================
    // Pin synchronisers
    logic [2:0] trg_sy, xck_sy;
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            trg_sy <= 3'h0;
            xck_sy <= 3'h0;
        end else if (CE) begin
            trg_sy <= {trg_sy[1:0], TRIGGER_GATE_INPUT};
            xck_sy <= {xck_sy[1:0], EXT_CLOCK_IRQ_INPUT};
        end
    end
    wire gate_hi = trg_sy[1];
    wire trg_rise = trg_sy[1] & ~trg_sy[2]; // R11
    wire xck_fall = ~xck_sy[1] & xck_sy[2];
    // ==========================================================
    // Registers
    logic [6:0] ctrl;
    logic [15:0] fast_count, slow_count;
    logic [DATA_W-1:0] sw_result;
    logic sw_busy, overrun;
    apt_src_t src;
    assign src = apt_src_t'(ctrl[`APT_CTRL_SRC_LSB +: 2]);
    wire trig_en = ctrl[`APT_CTRL_TRIG_BIT];
    wire gate_en = ctrl[`APT_CTRL_GATE_BIT] & ~trig_en; // R15
    wire casc = ctrl[`APT_CTRL_CASC_BIT];
    wire start = ctrl[`APT_CTRL_START_BIT];
    wire acc = PSEL & PENABLE & PREADY;
    wire wr = acc & PWRITE;
    wire rd = acc & ~PWRITE;
    wire rd_data = rd && PADDR == `APT_REG_DATA;
    wire sw_cmd = wr && PADDR == `APT_REG_SWCONV && src == APT_SRC_SW;
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl <= `APT_CTRL_RESET; // R24
            fast_count <= `APT_FAST_RESET;
            slow_count <= `APT_SLOW_RESET;
        end else if (CE && wr) begin
            if (PADDR == `APT_REG_CTRL)
                ctrl <= PWDATA[6:0];
            if (PADDR == `APT_REG_COUNT) begin
                fast_count <= PWDATA[15:0];
                slow_count <= PWDATA[31:16];
            end
        end
    end
    // ==========================================================
    // Time bases: 1 MHz tick and bus clock over two
    logic [6:0] tb_cnt;
    logic tb_tick, half_tick;
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            tb_cnt <= 7'h00;
            tb_tick <= 1'b0;
            half_tick <= 1'b0;
        end else if (CE) begin
            half_tick <= ~half_tick;
            tb_tick <= tb_cnt == 7'(`APT_TB_DIV - 1); // R2
            if (tb_cnt == 7'(`APT_TB_DIV - 1))
                tb_cnt <= 7'h00;
            else
                tb_cnt <= tb_cnt + 7'h01;
        end
    end
    // Base model keeps fast counter on bus clock over two until internal
    logic int_seen;
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN)
            int_seen <= 1'b0;
        else if (CE && src == APT_SRC_INT)
            int_seen <= 1'b1;
    end
    wire fast_tick = (BASE_MODEL && !int_seen) ? half_tick : tb_tick; // R5
    // ==========================================================
    // Pacing state machine
    apt_state_t state;
    logic [15:0] fast_cur, slow_cur;
    logic gate_q;
    logic pace;
    wire hw = src != APT_SRC_SW;
    wire gate_ok = !gate_en || gate_hi; // R14
    wire gate_rise = gate_en && gate_hi && !gate_q;
    wire fast_zero = fast_cur == 16'h0001;
    wire slow_zero = slow_cur == 16'h0001;
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            state <= APT_IDLE;
            fast_cur <= 16'h0000;
            slow_cur <= 16'h0000;
            gate_q <= 1'b0;
            pace <= 1'b0;
        end else if (CE) begin
            pace <= 1'b0;
            gate_q <= gate_hi;
            unique case (state)
                APT_IDLE: begin
                    if (start && hw) begin
                        // Trigger wait or gate hold-off first
                        if (trig_en || (gate_en && !gate_hi)) // R12 R15
                            state <= APT_WAIT;
                        else begin
                            state <= APT_RUN; // R10
                            pace <= src == APT_SRC_INT; // R1
                        end
                        fast_cur <= fast_count;
                        slow_cur <= slow_count;
                    end
                end
                APT_WAIT: begin
                    if (!start || !hw)
                        state <= APT_IDLE;
                    else if ((trig_en && trg_rise) ||
                             (!trig_en && gate_hi)) begin
                        state <= APT_RUN; // R13
                        pace <= src == APT_SRC_INT; // R12
                        fast_cur <= fast_count;
                        slow_cur <= slow_count;
                    end
                end
                APT_RUN: begin
                    if (!start || !hw)
                        state <= APT_IDLE;
                    else if (src == APT_SRC_EXT) begin
                        pace <= xck_fall && gate_ok; // R6 R16
                    end else if (gate_rise) begin
                        fast_cur <= fast_count; // R17
                        slow_cur <= slow_count;
                    end else if (gate_ok && fast_tick) begin
                        if (!fast_zero)
                            fast_cur <= fast_cur - 16'h0001;
                        else begin
                            fast_cur <= fast_count; // R4
                            if (!casc)
                                pace <= 1'b1; // R3
                            else if (slow_zero) begin
                                pace <= 1'b1;
                                slow_cur <= slow_count; // R25
                            end else
                                slow_cur <= slow_cur - 16'h0001; // R4
                        end
                    end
                end
                default: state <= APT_IDLE;
            endcase
        end
    end
    // ==========================================================
    // Conversion start, software result
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            CONV_START <= 1'b0;
            MASTER_PACE_OUTPUT <= 1'b0;
            sw_busy <= 1'b0;
            sw_result <= '0;
        end else if (CE) begin
            CONV_START <= pace || sw_cmd;
            MASTER_PACE_OUTPUT <= pace && src == APT_SRC_INT;
            if (sw_cmd)
                sw_busy <= 1'b1; // R23
            else if (CONV_DONE)
                sw_busy <= 1'b0;
            if (CONV_DONE && src == APT_SRC_SW)
                sw_result <= CONV_DATA;
        end
    end
    // ==========================================================
    // Result FIFO; oldest entry is overwritten on overflow
    logic [DATA_W-1:0] mem [DEPTH];
    logic [1:0] wp, rp;
    logic [2:0] cnt;
    wire push = CONV_DONE && hw; // R18
    wire pop = rd_data && cnt != 3'h0 && hw;
    wire full = cnt == 3'(DEPTH);
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            wp <= 2'h0;
            rp <= 2'h0;
            cnt <= 3'h0;
            overrun <= 1'b0;
        end else if (CE) begin
            if (!hw) begin
                wp <= 2'h0; // R19
                rp <= 2'h0;
                cnt <= 3'h0;
            end else begin
                if (push) begin
                    mem[wp] <= CONV_DATA;
                    wp <= wp + 2'h1;
                end
                if (push && full && !pop)
                    rp <= rp + 2'h1; // R20
                else if (pop)
                    rp <= rp + 2'h1;
                if (push && !pop && !full)
                    cnt <= cnt + 3'h1;
                else if (pop && !push)
                    cnt <= cnt - 3'h1;
            end
            // Set wins over the clear by status read
            if (push && full && !pop)
                overrun <= 1'b1; // R20
            else if (rd && PADDR == `APT_REG_STATUS)
                overrun <= 1'b0;
        end
    end
    // ==========================================================
    // Interrupt outputs and APB read path
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            EOC_IRQ <= 1'b0;
            EXT_IRQ_REQ <= 1'b0;
            PRDATA <= 32'h0;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else if (CE) begin
            EOC_IRQ <= ctrl[`APT_CTRL_EOCIE_BIT] &&
                (hw ? cnt != 3'h0 : !sw_busy); // R21
            EXT_IRQ_REQ <= src != APT_SRC_EXT && xck_sy[1]; // R7
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0;
            if (PSEL && !PENABLE) begin
                unique case (PADDR)
                    `APT_REG_CTRL: PRDATA <= {25'h0, ctrl};
                    `APT_REG_COUNT: PRDATA <= {slow_count, fast_count};
                    `APT_REG_STATUS: PRDATA <= {27'h0,
                        state == APT_WAIT, sw_busy, overrun,
                        full, cnt == 3'h0};
                    `APT_REG_DATA: PRDATA <= 32'(hw ? mem[rp] : sw_result); // R22
                    `APT_REG_SWCONV: PRDATA <= 32'h0;
                    default: PSLVERR <= 1'b1;
                endcase
            end
        end
    end
    // ==========================================================
    // Checks
    chk_sw_clears_fifo: assert property (@(posedge CLOCK) disable iff (!RSTN)
        CE && !hw |=> cnt == 3'h0) else $error("fifo not cleared"); // R19
    chk_ovr_on_full: assert property (@(posedge CLOCK) disable iff (!RSTN)
        CE && hw && push && full && !pop |=> overrun)
        else $error("overrun missed"); // R20
    chk_ext_pace: assert property (@(posedge CLOCK) disable iff (!RSTN)
        CE && state == APT_RUN && src == APT_SRC_EXT && xck_fall &&
        gate_ok && start |=> pace) else $error("ext edge lost"); // R6
    chk_gate_block: assert property (@(posedge CLOCK) disable iff (!RSTN)
        pace |-> $past(gate_ok)) else $error("gated pace"); // R14
    sequence s_start_int;
        CE && state == APT_IDLE && start && src == APT_SRC_INT &&
            !trig_en && gate_ok;
    endsequence
    chk_start_immediate: assert property (@(posedge CLOCK)
        disable iff (!RSTN) s_start_int |=> pace ##1 CONV_START)
        else $error("no start conversion"); // R1
    chk_ext_no_irq: assert property (@(posedge CLOCK) disable iff (!RSTN)
        CE && src == APT_SRC_EXT |=> !EXT_IRQ_REQ)
        else $error("irq on ext clock"); // R7
    chk_trig_wait: assert property (@(posedge CLOCK) disable iff (!RSTN)
        CE && state == APT_WAIT && trig_en && !trg_rise && start && hw
        |=> !pace) else $error("pace before trigger"); // R12
    chk_cnt_bound: assert property (@(posedge CLOCK) disable iff (!RSTN)
        cnt <= 3'(DEPTH)) else $error("fifo count overflow"); // R18
endmodule // apt_top
`default_nettype wire

// ---- bench/apt_conv_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ====
// Converter stand-in: answers each start after lat cycles
module apt_conv_model #(
    parameter int DATA_W = 12
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic conv_start,
    input wire logic [7:0] lat,
    output logic conv_done,
    output logic [DATA_W-1:0] conv_data
);
    integer seed = 60648;
    logic [7:0] cnt;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            conv_done <= 1'b0;
            conv_data <= '0;
            cnt <= 8'h00;
        end else begin
            conv_done <= 1'b0;
            if (conv_start) begin
                cnt <= lat;
            end else if (cnt > 8'h01) begin
                cnt <= cnt - 8'h01;
            end else if (cnt == 8'h01) begin
                cnt <= 8'h00;
                conv_done <= 1'b1;
                conv_data <= DATA_W'($random(seed));
            end else begin
                // Data only valid with done; invert the stale word while idle
                conv_data <= ~conv_data;
            end
        end
    end
endmodule // apt_conv_model
`default_nettype wire

// ---- bench/tb_adc_pacing_trigger_gate_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "apt_defs.svh"
module tb_adc_pacing_trigger_gate_fifo;
    logic clock, rstn, psel, penable, pwrite, pready, pslverr, err;
    logic tgi, xclk, conv_start, conv_done, ext_irq, eoc_irq, pace;
    logic [11:0] paddr, conv_data, last_data;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] lat;
    int error_cnt, num_checks, starts, cyc, last_t, last_gap, s0;
    int paces, p0;
    int q[$];
    bit hw;
    apt_top i_apt_top (.CLOCK(clock), .RSTN(rstn), .CE(1'b1),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .TRIGGER_GATE_INPUT(tgi),
        .EXT_CLOCK_IRQ_INPUT(xclk), .CONV_START(conv_start),
        .CONV_DONE(conv_done), .CONV_DATA(conv_data),
        .EXT_IRQ_REQ(ext_irq), .EOC_IRQ(eoc_irq),
        .MASTER_PACE_OUTPUT(pace));
    apt_conv_model i_apt_conv_model (.clock(clock), .rstn(rstn),
        .conv_start(conv_start), .lat(lat), .conv_done(conv_done),
        .conv_data(conv_data));
    // ====
    // Reference model: start timing and four-word buffer
    always @(posedge clock) begin
        cyc++;
        if (pace === 1'b1) paces++;
        if (conv_start === 1'b1) begin
            starts++;
            last_gap = cyc - last_t;
            last_t = cyc;
        end
        if (conv_done === 1'b1) begin
            last_data = conv_data;
            if (hw) begin
                q.push_back(conv_data);
                // Oldest unread word is lost on overflow
                if (q.size() > 4) void'(q.pop_front());
            end
        end
    end
    // ====
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        // A slave that never answers counts against the run
        if (pready !== 1'b1) error_cnt++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic set_ctrl(input logic [31:0] d);
        hw = (d[1:0] != 2'd0);
        if (!hw) q.delete();
        apb(1'b1, `APT_REG_CTRL, d);
    endtask
    task automatic wait_starts(input int n);
        int t0;
        t0 = starts;
        for (int k = 0; k < 20000 && starts < t0 + n; k++) @(posedge clock);
        if (starts < t0 + n) error_cnt++;
    endtask
    task automatic xedges(input int n);
        repeat (n) begin
            repeat (1600) @(posedge clock);
            xclk <= 1'b0; // Falling edges 25.6 us apart
            repeat (1600) @(posedge clock);
            xclk <= 1'b1;
        end
        repeat (10) @(posedge clock);
    endtask
    // ====
    // Clock, watchdog, tests
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        #800000;
        error_cnt++;
        end_sim();
    end
    initial begin
        {rstn, psel, penable, pwrite, tgi, hw} = '0;
        paddr = '0;
        pwdata = '0;
        xclk = 1'b1;
        lat = 8'd40;
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        apb(1'b0, `APT_REG_CTRL, 0);
        chk(rd, 32'h0);
        apb(1'b0, `APT_REG_COUNT, 0);
        chk(rd, {`APT_SLOW_RESET, `APT_FAST_RESET});
        apb(1'b0, 12'h020, 0);
        chk(32'(err), 32'h1);
        chk(32'(ext_irq), 32'h1);
        $display("test 1 done");
        // Slow converter answer forces the host to poll
        set_ctrl(32'h20);
        apb(1'b1, `APT_REG_SWCONV, 0);
        for (int k = 0; k < 20; k++) begin
            apb(1'b0, `APT_REG_STATUS, 0);
            if (rd[`APT_ST_BUSY_BIT] === 1'b0) break;
        end
        apb(1'b0, `APT_REG_DATA, 0);
        chk(rd, {20'h0, last_data});
        chk(32'(eoc_irq), 32'h1);
        $display("test 2 done");
        lat <= 8'd2;
        p0 = paces;
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, `APT_REG_COUNT, i ? 32'h0002000d : 32'h00010019);
            set_ctrl(i ? 32'h51 : 32'h41);
            wait_starts(3);
            chk(last_gap, i ? 3250 : 3125);
            wait_starts(3);
            set_ctrl(i ? 32'h11 : 32'h01);
            repeat (10) @(posedge clock);
            apb(1'b0, `APT_REG_STATUS, 0);
            chk(rd[2:0], 3'b110);
            for (int k = 0; k < 4; k++) begin
                apb(1'b0, `APT_REG_DATA, 0);
                chk(rd, q.pop_front());
            end
            set_ctrl(32'h0);
            apb(1'b0, `APT_REG_STATUS, 0);
            chk(rd[2:0], 3'b001);
            $display("test %0d done", 3 + i);
        end
        chk(paces - p0, 12);
        set_ctrl(32'h42);
        s0 = starts;
        xedges(4);
        chk(starts - s0, 4);
        chk(32'(ext_irq), 32'h0);
        chk(paces - p0, 12);
        set_ctrl(32'h4a);
        s0 = starts;
        xedges(2);
        chk(starts - s0, 0);
        tgi <= 1'b1;
        xedges(2);
        chk(starts - s0, 2);
        set_ctrl(32'h0);
        tgi <= 1'b0;
        $display("test 5 done");
        apb(1'b1, `APT_REG_COUNT, 32'h00010019);
        set_ctrl(32'h45);
        s0 = starts;
        repeat (4000) @(posedge clock);
        chk(starts - s0, 0);
        tgi <= 1'b1;
        repeat (20) @(posedge clock);
        chk(starts - s0, 1);
        set_ctrl(32'h0);
        tgi <= 1'b0;
        $display("test 6 done");
        repeat (10) @(posedge clock);
        set_ctrl(32'h46);
        s0 = starts;
        xedges(1);
        chk(starts - s0, 0);
        tgi <= 1'b1;
        repeat (10) @(posedge clock);
        chk(starts - s0, 0);
        xedges(1);
        chk(starts - s0, 1);
        set_ctrl(32'h0);
        tgi <= 1'b0;
        $display("test 7 done");
        end_sim();
    end
endmodule // tb_adc_pacing_trigger_gate_fifo
`default_nettype wire
